/* hw/pcrc_map.svh */
// Offsets, field positions, fixed values and timing counts of the ROM and capability registers
`ifndef PCRC_MAP_SVH
`define PCRC_MAP_SVH

// Configuration byte offsets
`define PCRC_OFS_ROM_BASE   8'h30
`define PCRC_OFS_CAP_START  8'h34
`define PCRC_OFS_INT_LINE   8'h3C
`define PCRC_OFS_INT_PIN    8'h3D
`define PCRC_OFS_BURST_NEED 8'h3E
`define PCRC_OFS_ARB_WAIT   8'h3F
`define PCRC_OFS_CAP_IDENT  8'h40
`define PCRC_OFS_NEXT_CAP   8'h41

// Expansion ROM base register fields
`define PCRC_ROM_BASE_MSB   31
`define PCRC_ROM_BASE_LSB   20
`define PCRC_ROM_EN_BIT     0
`define PCRC_ROM_BASE_RST   12'h000
`define PCRC_ROM_EN_RST     1'b0

// Fixed read values
`define PCRC_CAP_START_VAL  8'h40
`define PCRC_INT_PIN_VAL    8'h01
`define PCRC_CAP_IDENT_VAL  8'h01
`define PCRC_NEXT_CAP_VAL   8'h00
`define PCRC_INT_LINE_RST   8'h00

// Fields of the internal bus configuration word twenty-two
`define PCRC_BURST_NEED_MSB 7
`define PCRC_BURST_NEED_LSB 0
`define PCRC_ARB_WAIT_MSB   15
`define PCRC_ARB_WAIT_LSB   8

// Latency unit, quarter microsecond at a 33 MHz bus
`define PCRC_LAT_UNIT_NS    250
`define PCRC_LAT_BUS_MHZ    33

// Memory commands that may address the ROM window
`define PCRC_CMD_MEM_RD     4'h6
`define PCRC_CMD_MEM_WR     4'h7
`define PCRC_CMD_MEM_RDM    4'hC
`define PCRC_CMD_MEM_RDL    4'hE
`define PCRC_CMD_MEM_WRI    4'hF

`endif

/* hw/pcrc_pkg.sv */
// Types shared by the ROM and capability register bank
package pcrc_pkg;

  // Which configuration dword an access selects
  typedef enum logic [2:0] {
    PCRC_SEL_ROM,
    PCRC_SEL_CAPSTART,
    PCRC_SEL_INTR,
    PCRC_SEL_PMCAP,
    PCRC_SEL_NONE
  } pcrc_cfg_sel_t;

  // ROM window base, upper address bits
  typedef logic [11:0] pcrc_rom_base_t;

  // Dword offset inside the one-megabyte window
  typedef logic [17:0] pcrc_rom_word_t;

endpackage : pcrc_pkg

/* hw/pcrc_dec_if.sv */
// Carrier between the register bank and its ROM address decoder
`timescale 1ns/1ps
`default_nettype none

interface pcrc_dec_if;
  import pcrc_pkg::*;

  logic           addr_phase;
  logic [3:0]     bus_cmd;
  logic [31:0]    bus_ad;
  pcrc_rom_base_t base;
  logic           rom_en;
  logic           mem_en;
  logic           hit;
  pcrc_rom_word_t word;

  modport regs (output addr_phase, bus_cmd, bus_ad, base, rom_en, mem_en, input hit, word);
  modport dec  (input addr_phase, bus_cmd, bus_ad, base, rom_en, mem_en, output hit, word);

endinterface : pcrc_dec_if

`default_nettype wire

/* hw/pcrc_rom_decode.sv */
// Address decoder that recognises memory cycles aimed at the expansion ROM window
`timescale 1ns/1ps
`default_nettype none

`include "pcrc_map.svh"

module pcrc_rom_decode
  import pcrc_pkg::*;
(
  pcrc_dec_if.dec dif
);

  // True for every memory command that can read or write the window
  function automatic logic pcrc_is_mem_cmd(input logic [3:0] cmd);
    pcrc_is_mem_cmd = (cmd == `PCRC_CMD_MEM_RD)  ||
                      (cmd == `PCRC_CMD_MEM_WR)  ||
                      (cmd == `PCRC_CMD_MEM_RDM) ||
                      (cmd == `PCRC_CMD_MEM_RDL) ||
                      (cmd == `PCRC_CMD_MEM_WRI);
  endfunction : pcrc_is_mem_cmd

  // Window is one megabyte on a megabyte boundary, so base to base+1M-4 is an upper-bit match
  always_comb begin
    dif.hit  = dif.addr_phase &&
               dif.rom_en && dif.mem_en && // RL5
               pcrc_is_mem_cmd(dif.bus_cmd) &&
               (dif.bus_ad[`PCRC_ROM_BASE_MSB:`PCRC_ROM_BASE_LSB] == dif.base); // RL2
    dif.word = dif.bus_ad[19:2];
  end

endmodule : pcrc_rom_decode

`default_nettype wire

/* hw/pcrc_regs.sv */
// Configuration registers 30h to 41h: expansion ROM base with window claim, and capability bytes
`timescale 1ns/1ps
`default_nettype none

`include "pcrc_map.svh"

// Operation
// RL1 - Host-writable 12-bit ROM base in bits 31-20, any megabyte boundary.
// RL2 - With both enables set, claim memory commands whose address falls in the window.
// RL3 - ROM base is read/write, cleared by hardware reset only.
// RL4 - Bits 19-1 read zero, ignore writes; all-ones probe shows one megabyte.
// RL5 - Bit 0 enables ROM; answer only while it and memory enable are set.
// RL6 - ROM enable is read/write, cleared by hardware reset only.
// RL7 - Host loads a valid base before setting either enable.
// RL8 - Offset 34h reads 40h, read-only, start of capability list.
// RL9 - Offset 3Ch is a plain host store, never changed by the device.
// RL10 - Offset 3Dh reads 01h, read-only, meaning interrupt line A.
// RL11 - Offset 3Eh reads bits 7-0 of bus configuration word twenty-two.
// RL12 - Offset 3Fh reads bits 15-8 of bus configuration word twenty-two.
// RL13 - Grant and latency values count quarter microseconds at 33 MHz.
// RL14 - Software should program configuration word twenty-two to 1818h.
// RL15 - Host derives its latency timer from the grant and latency values.
// RL16 - Offset 40h reads 01h, read-only, power management capability.
// RL17 - Offset 41h reads 00h, read-only, end of capability list.
// RL18 - Writes to read-only bytes complete normally and change nothing.
module pcrc_regs
  import pcrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration access, one-cycle strobe on the bus clock
  input  wire logic        cfg_sel,
  input  wire logic        cfg_write,
  input  wire logic [5:0]  cfg_dword,
  input  wire logic [3:0]  cfg_be_n,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_done,
  // Neighbouring state of the configuration header
  input  wire logic        memory_space_enable,
  input  wire logic [15:0] bus_config_twenty_two,
  // Address phase of a bus cycle
  input  wire logic        addr_phase,
  input  wire logic [3:0]  bus_cmd,
  input  wire logic [31:0] bus_ad,
  output logic             rom_claim,
  output logic      [17:0] rom_word_addr,
  // Register state for the rest of the device
  output logic             rom_access_enable,
  output logic      [11:0] rom_window_base,
  output logic      [7:0]  interrupt_routing_line
);

  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nxt_rst_meta;
  logic nxt_rst_sync;

  // Stored registers
  pcrc_rom_base_t rom_base_ff;
  pcrc_rom_base_t nxt_rom_base;
  logic           rom_en_ff;
  logic           nxt_rom_en;
  logic [7:0]     int_line_ff;
  logic [7:0]     nxt_int_line;

  // Read path and completion
  logic [31:0]    rdata_ff;
  logic [31:0]    nxt_rdata;
  logic           done_ff;
  logic           nxt_done;

  // Window claim
  logic           claim_ff;
  logic           nxt_claim;
  pcrc_rom_word_t word_ff;
  pcrc_rom_word_t nxt_word;

  // Decoder carrier
  pcrc_dec_if dif ();

  // Map a dword index onto the register group it selects
  function automatic pcrc_cfg_sel_t pcrc_cfg_decode(input logic [5:0] dw);
    logic [7:0] ofs;
    ofs = {dw, 2'b00};
    if (ofs == `PCRC_OFS_ROM_BASE) begin
      pcrc_cfg_decode = PCRC_SEL_ROM;
    end else if (ofs == `PCRC_OFS_CAP_START) begin
      pcrc_cfg_decode = PCRC_SEL_CAPSTART;
    end else if (ofs == `PCRC_OFS_INT_LINE) begin
      pcrc_cfg_decode = PCRC_SEL_INTR;
    end else if (ofs == `PCRC_OFS_CAP_IDENT) begin
      pcrc_cfg_decode = PCRC_SEL_PMCAP;
    end else begin
      pcrc_cfg_decode = PCRC_SEL_NONE;
    end
  endfunction : pcrc_cfg_decode

  // Release of the reset goes through two flops so every flop below leaves reset on one edge
  always_comb begin
    nxt_rst_meta = 1'b1;
    nxt_rst_sync = rst_meta_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= nxt_rst_meta;
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  // Host writes, merged by byte lane
  // Only hardware reset clears these; there is no soft-reset or stop input on purpose
  always_comb begin
    nxt_rom_base = rom_base_ff;
    nxt_rom_en   = rom_en_ff;
    nxt_int_line = int_line_ff;
    if (cfg_sel && cfg_write) begin
      unique case (pcrc_cfg_decode(cfg_dword))
        PCRC_SEL_ROM: begin
          if (!cfg_be_n[3]) begin
            nxt_rom_base[11:4] = cfg_wdata[31:24]; // RL1
          end
          if (!cfg_be_n[2]) begin
            nxt_rom_base[3:0] = cfg_wdata[23:`PCRC_ROM_BASE_LSB]; // RL1
          end
          if (!cfg_be_n[0]) begin
            nxt_rom_en = cfg_wdata[`PCRC_ROM_EN_BIT]; // RL5
          end
          // Bits 19-1 have no storage, so a write there is simply dropped
        end
        PCRC_SEL_INTR: begin
          // Only byte 0 is storage; pin, grant and latency bytes ignore the write
          if (!cfg_be_n[0]) begin
            nxt_int_line = cfg_wdata[7:0]; // RL9
          end
        end
        PCRC_SEL_CAPSTART,
        PCRC_SEL_PMCAP,
        PCRC_SEL_NONE: begin
          // Read-only or unmapped: accepted, nothing stored
          nxt_rom_base = rom_base_ff; // RL18
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rom_base_ff <= `PCRC_ROM_BASE_RST; // RL3
      rom_en_ff   <= `PCRC_ROM_EN_RST;   // RL6
      int_line_ff <= `PCRC_INT_LINE_RST; // RL9
    end else begin
      rom_base_ff <= nxt_rom_base; // RL3
      rom_en_ff   <= nxt_rom_en;   // RL6
      int_line_ff <= nxt_int_line;
    end
  end

  // Read data for the selected dword; every access is answered one cycle later
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_done  = cfg_sel; // RL18
    if (cfg_sel && !cfg_write) begin
      unique case (pcrc_cfg_decode(cfg_dword))
        PCRC_SEL_ROM: begin
          nxt_rdata = 32'h0000_0000; // RL4
          nxt_rdata[`PCRC_ROM_BASE_MSB:`PCRC_ROM_BASE_LSB] = rom_base_ff; // RL3
          nxt_rdata[`PCRC_ROM_EN_BIT] = rom_en_ff; // RL6
        end
        PCRC_SEL_CAPSTART: begin
          nxt_rdata = {24'h00_0000, `PCRC_CAP_START_VAL}; // RL8
        end
        PCRC_SEL_INTR: begin
          // Grant and latency pass in raw quarter-microsecond units; no scaling here
          nxt_rdata = {bus_config_twenty_two[`PCRC_ARB_WAIT_MSB:`PCRC_ARB_WAIT_LSB], // RL12 RL13
                       bus_config_twenty_two[`PCRC_BURST_NEED_MSB:`PCRC_BURST_NEED_LSB], // RL11 RL13
                       `PCRC_INT_PIN_VAL, // RL10
                       int_line_ff};      // RL9
        end
        PCRC_SEL_PMCAP: begin
          // Upper half belongs to the power management capabilities word kept elsewhere
          nxt_rdata = {16'h0000, `PCRC_NEXT_CAP_VAL, `PCRC_CAP_IDENT_VAL}; // RL16 RL17
        end
        PCRC_SEL_NONE: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data holds until the next read, so a slow master can pick it up late
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 32'h0000_0000;
      done_ff  <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
    end
  end

  // Feed the decoder with the live address phase and the stored enables
  // The host is trusted to set a base before enabling; a stale base is decoded as is
  always_comb begin
    dif.addr_phase = addr_phase;
    dif.bus_cmd    = bus_cmd;
    dif.bus_ad     = bus_ad;
    dif.base       = rom_base_ff;         // RL7
    dif.rom_en     = rom_en_ff;
    dif.mem_en     = memory_space_enable;
  end

  pcrc_rom_decode u_rom_decode (
    .dif (dif.dec)
  );

  // Claim flag for the bus target; the word offset is held for the ROM reader
  always_comb begin
    nxt_claim = dif.hit; // RL2
    nxt_word  = word_ff;
    if (dif.hit) begin
      nxt_word = dif.word;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      claim_ff <= 1'b0;
      word_ff  <= 18'h0_0000;
    end else begin
      claim_ff <= nxt_claim;
      word_ff  <= nxt_word;
    end
  end

  // Outputs straight from flops
  assign cfg_rdata              = rdata_ff;
  assign cfg_done               = done_ff;
  assign rom_claim              = claim_ff; // RL2
  assign rom_word_addr          = word_ff;
  assign rom_access_enable      = rom_en_ff;
  assign rom_window_base        = rom_base_ff;
  assign interrupt_routing_line = int_line_ff;

endmodule : pcrc_regs

`default_nettype wire

/* tb/pcrc_chk.sv */
// Port checker of the ROM and capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcrc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cfg_sel,
  input wire logic        cfg_write,
  input wire logic [5:0]  cfg_dword,
  input wire logic [3:0]  cfg_be_n,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_done,
  input wire logic        memory_space_enable,
  input wire logic [15:0] bus_config_twenty_two,
  input wire logic        addr_phase,
  input wire logic [3:0]  bus_cmd,
  input wire logic [31:0] bus_ad,
  input wire logic        rom_claim,
  input wire logic [17:0] rom_word_addr,
  input wire logic        rom_access_enable,
  input wire logic [11:0] rom_window_base,
  input wire logic [7:0]  interrupt_routing_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reads and cycle hits, decoded once
  logic rd_q;
  logic hit;
  logic [17:0] ad_word;
  assign rd_q = cfg_sel && !cfg_write;
  assign ad_word = bus_ad[19:2];
  assign hit = addr_phase && (bus_cmd inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF}) && bus_ad[31:20] == rom_window_base;
  property p_done; cfg_sel |=> cfg_done; endproperty
  a_done: assert property (p_done) else $error("no done after access");
  property p_lone_done; cfg_done |-> $past(cfg_sel); endproperty
  a_lone_done: assert property (p_lone_done) else $error("done without access");
  property p_claim; hit && rom_access_enable && memory_space_enable |=> rom_claim; endproperty
  a_claim: assert property (p_claim) else $error("window hit not claimed");
  property p_quiet; !(hit && rom_access_enable && memory_space_enable) |=> !rom_claim; endproperty
  a_quiet: assert property (p_quiet) else $error("claim without enabled hit");
  property p_word; rom_claim |-> rom_word_addr == $past(ad_word); endproperty
  a_word: assert property (p_word) else $error("claimed word address wrong");
  property p_base_hold; !(cfg_sel && cfg_write) |=> $stable(rom_window_base) && $stable(rom_access_enable); endproperty
  a_base_hold: assert property (p_base_hold) else $error("rom register moved without write");
  property p_line_hold; !(cfg_sel && cfg_write) |=> $stable(interrupt_routing_line); endproperty
  a_line_hold: assert property (p_line_hold) else $error("line byte moved without write");
  property p_rd_rom; rd_q && cfg_dword == 6'h0C |=> cfg_rdata == {rom_window_base, 19'h0, rom_access_enable}; endproperty
  a_rd_rom: assert property (p_rd_rom) else $error("rom register read wrong");
  property p_rd_int; rd_q && cfg_dword == 6'h0F |=> cfg_rdata == {$past(bus_config_twenty_two), 8'h01, interrupt_routing_line}; endproperty
  a_rd_int: assert property (p_rd_int) else $error("interrupt dword read wrong");
endmodule : pcrc_chk
bind pcrc_regs pcrc_chk u_chk (.clk(clk), .rst_n(rst_n), .cfg_sel(cfg_sel), .cfg_write(cfg_write),
  .cfg_dword(cfg_dword), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done),
  .memory_space_enable(memory_space_enable), .bus_config_twenty_two(bus_config_twenty_two),
  .addr_phase(addr_phase), .bus_cmd(bus_cmd), .bus_ad(bus_ad), .rom_claim(rom_claim),
  .rom_word_addr(rom_word_addr), .rom_access_enable(rom_access_enable), .rom_window_base(rom_window_base),
  .interrupt_routing_line(interrupt_routing_line));
`default_nettype wire

/* tb/pcrc_host.sv */
// Host bridge model issuing configuration accesses and memory address phases
`timescale 1ns/1ps
`default_nettype none
module pcrc_host (
  input  wire logic        clk,
  output logic             cfg_sel = 1'b0,
  output logic             cfg_write = 1'b0,
  output logic      [5:0]  cfg_dword = 6'h00,
  output logic      [3:0]  cfg_be_n = 4'hF,
  output logic      [31:0] cfg_wdata = 32'h0000_0000,
  output logic             addr_phase = 1'b0,
  output logic      [3:0]  bus_cmd = 4'h0,
  output logic      [31:0] bus_ad = 32'h0000_0000
);
  // One access; the write data is inverted on release so stale data never looks valid
  task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_sel <= 1'b1;
    cfg_write <= wr;
    cfg_dword <= dw;
    cfg_be_n <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_sel <= 1'b0;
    cfg_wdata <= ~d;
    #1;
  endtask : cfg
  // One address phase of a bus cycle
  task automatic addr(input logic [3:0] cmd, input logic [31:0] ad);
    @(posedge clk);
    addr_phase <= 1'b1;
    bus_cmd <= cmd;
    bus_ad <= ad;
    @(posedge clk);
    addr_phase <= 1'b0;
    bus_ad <= ~ad;
    #1;
  endtask : addr
endmodule : pcrc_host
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the ROM and capability register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mse = 1'b1;
  logic [15:0] bcr = 16'h1818;
  logic        sel, wr, done, ap, claim, ren;
  logic [3:0]  be_n, cmd;
  logic [5:0]  dw;
  logic [31:0] wd, rdat, ad;
  logic [17:0] word;
  logic [11:0] base;
  logic [7:0]  iline;
  int          n_errors = 0;
  int          compares = 0;
  pcrc_host host (.clk(clk), .cfg_sel(sel), .cfg_write(wr), .cfg_dword(dw), .cfg_be_n(be_n), .cfg_wdata(wd),
    .addr_phase(ap), .bus_cmd(cmd), .bus_ad(ad));
  pcrc_regs uut (.clk(clk), .rst_n(rst_n), .cfg_sel(sel), .cfg_write(wr), .cfg_dword(dw), .cfg_be_n(be_n),
    .cfg_wdata(wd), .cfg_rdata(rdat), .cfg_done(done), .memory_space_enable(mse), .bus_config_twenty_two(bcr),
    .addr_phase(ap), .bus_cmd(cmd), .bus_ad(ad), .rom_claim(claim), .rom_word_addr(word),
    .rom_access_enable(ren), .rom_window_base(base), .interrupt_routing_line(iline));
  always #5 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Register access helpers; the done pulse is checked on every access
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    host.cfg(1'b0, a, 4'h0, 32'h0000_0000);
    check(done, 1'b1);
    check(rdat, exp);
  endtask : rd
  task automatic wrt(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    host.cfg(1'b1, a, b, d);
    check(done, 1'b1);
  endtask : wrt
  // A miss must also leave the last claimed word untouched
  task automatic hit(input logic [3:0] c, input logic [31:0] a, input logic e, input logic [17:0] w);
    host.addr(c, a);
    check(claim, e);
    check(word, w);
  endtask : hit
  task automatic t_reset_values();
    rd(6'h0C, 32'h0000_0000);
    rd(6'h0F, 32'h1818_0100);
  endtask : t_reset_values
  task automatic t_rom_reg();
    wrt(6'h0C, 4'h0, 32'hFFFF_FFFF);
    rd(6'h0C, 32'hFFF0_0001);
    wrt(6'h0C, 4'hE, 32'h0000_0000);
    wrt(6'h0C, 4'h3, 32'hABC0_0000);
    wrt(6'h0C, 4'hE, 32'h0000_0001);
    rd(6'h0C, 32'hABC0_0001);
    check(base, 12'hABC);
    check(ren, 1'b1);
  endtask : t_rom_reg
  task automatic t_fixed();
    @(posedge clk);
    bcr <= 16'h5AA5;
    wrt(6'h0D, 4'h0, 32'hFFFF_FFFF);
    wrt(6'h10, 4'h0, 32'hFFFF_FFFF);
    wrt(6'h0F, 4'h0, 32'hFFFF_FFFF);
    wrt(6'h0E, 4'h0, 32'hFFFF_FFFF);
    rd(6'h0D, 32'h0000_0040);
    rd(6'h10, 32'h0000_0001);
    rd(6'h0F, 32'h5AA5_01FF);
    rd(6'h0E, 32'h0000_0000);
  endtask : t_fixed
  task automatic t_claim();
    logic [3:0] mem[5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    foreach (mem[i]) hit(mem[i], 32'hABC0_123C, 1'b1, 18'h0_048F);
    hit(4'h6, 32'hABCF_FFFF, 1'b1, 18'h3_FFFF);
    hit(4'h6, 32'hABBF_FFFC, 1'b0, 18'h3_FFFF);
    hit(4'h7, 32'hABD0_0000, 1'b0, 18'h3_FFFF);
    hit(4'h2, 32'hABC0_0000, 1'b0, 18'h3_FFFF);
    @(posedge clk);
    mse <= 1'b0;
    hit(4'h6, 32'hABC0_0000, 1'b0, 18'h3_FFFF);
    @(posedge clk);
    mse <= 1'b1;
    wrt(6'h0C, 4'hE, 32'h0000_0000);
    hit(4'h6, 32'hABC0_0000, 1'b0, 18'h3_FFFF);
  endtask : t_claim
  task automatic t_mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(iline, 8'h00);
    check(base, 12'h000);
    check(ren, 1'b0);
    check(word, 18'h0_0000);
    rd(6'h0C, 32'h0000_0000);
  endtask : t_mid_reset
  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Whole run is under a hundred cycles; the limit of 5000 cycles leaves ample margin
  initial begin
    #50_000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_rom_reg();
    t_fixed();
    t_claim();
    t_mid_reset();
    finish_test();
  end
endmodule : tb
`default_nettype wire
